// ==== rtl/smc_pkg.sv ====
// Shared constants and types of the standby mode controller
package smc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SMC_AW = 16;
  localparam int SMC_DW = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] SMC_ADDR_POWER_CONTROL_REG = 16'hfe07;
  localparam logic [15:0] SMC_ADDR_WDOG = 16'hfe0f;
  localparam logic [15:0] SMC_ADDR_XTPC = 16'hfe43;
  localparam logic [15:0] SMC_ADDR_ISTAT = 16'hfe50;
  localparam logic [15:0] SMC_ADDR_IMASK = 16'hfe51;
  localparam logic [15:0] SMC_ADDR_STATE = 16'hfe52;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SMC_POWER_CONTROL_REG_HALT_BIT = 0;
  localparam int SMC_POWER_CONTROL_REG_HOLD_BIT = 1;
  localparam int SMC_POWER_CONTROL_REG_SUB_BIT = 2;
  localparam int SMC_XTPC_SEL_BIT = 3;
  localparam int SMC_WDOG_CLR_EN_BIT = 4;
  localparam int SMC_IRQ_HALT_WAKE = 0;
  localparam int SMC_IRQ_HOLD_WAKE = 1;
  localparam int SMC_IRQ_RESET_EXIT = 2;
  localparam int SMC_IRQ_CLK_READY = 3;

  // ----------------------------------------------------------------
  // Values after reset and the watchdog clear mask
  // ----------------------------------------------------------------
  localparam logic [7:0] SMC_POWER_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] SMC_WDOG_RST = 8'h00;
  localparam logic [7:0] SMC_XTPC_RST = 8'h00;
  localparam logic [7:0] SMC_IMASK_RST = 8'h00;
  localparam logic [7:0] SMC_WDOG_CNT_MASK = 8'hf8;

  // ----------------------------------------------------------------
  // Timing: least time the CPU reset stays up after its cause clears
  // ----------------------------------------------------------------
  localparam int SMC_CLK_MHZ = 250;
  localparam int SMC_RST_HOLD_NS = 40;
  localparam int SMC_RST_HOLD_CYC = (SMC_RST_HOLD_NS * SMC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SMC_RST_HOLD_CNT = 8'(SMC_RST_HOLD_CYC);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SMC_ST_RESET = 3'h0,
    SMC_ST_NORMAL = 3'h1,
    SMC_ST_HALT = 3'h2,
    SMC_ST_HOLD = 3'h3,
    SMC_ST_SUBHOLD = 3'h4,
    SMC_ST_WAKE = 3'h5
  } smc_state_e;

  typedef struct packed {
    logic external_interrupt_0;
    logic external_interrupt_1;
    logic external_interrupt_2;
    logic external_interrupt_4;
    logic external_interrupt_5;
    logic port0_wake_interrupt;
    logic base_timer;
    logic remote_rx;
    logic other;
  } smc_wake_s;

  typedef struct packed {
    logic cpu_run;
    logic cpu_reset;
    logic periph_run;
    logic serial_tx_en;
    logic base_timer_run;
    logic main_osc_en;
    logic sub_osc_en;
    logic osc_pin_gpio;
  } smc_ctl_s;

endpackage : smc_pkg

// ==== rtl/smc_standby.sv ====
// Standby mode controller: normal, halt, hold and subclock hold sequencing
// Functional notes
// - Reset cause during standby enters reset state
// - Halt disables serial transmit, others keep state
// - Other peripherals run in halt, stop in holds
// - Base timer stops in reset and hold
// - Halt wake returns normal, clears power bit0
// - Hold wakes by listed interrupts, clears bit1
// - Pin select from bit3, frozen during hold
// - Hold entry sets power control bit0
// - Standby entry clears watchdog bits when enabled
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module smc_standby
  import smc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [SMC_AW-1:0] ADDR_IN,
  input wire logic [SMC_DW-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [SMC_DW-1:0] RDATA_OUT,
  input wire smc_wake_s WAKE_IN,
  input wire logic EXT_RESET_PIN_IN,
  input wire logic WDOG_RESET_IN,
  input wire logic MAIN_CLK_READY_IN,
  output smc_ctl_s CTL_OUT,
  output logic [2:0] STATE_OUT,
  output logic IRQ_OUT
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic ext_rst_meta;
  logic ext_rst_sync;
  logic clk_rdy_meta;
  logic clk_rdy_sync;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ext_rst_meta <= 1'b0;
      ext_rst_sync <= 1'b0;
    end else begin
      ext_rst_meta <= EXT_RESET_PIN_IN;
      ext_rst_sync <= ext_rst_meta;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      clk_rdy_meta <= 1'b0;
      clk_rdy_sync <= 1'b0;
    end else begin
      clk_rdy_meta <= MAIN_CLK_READY_IN;
      clk_rdy_sync <= clk_rdy_meta;
    end
  end

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  smc_state_e state;
  smc_state_e next_state;
  smc_state_e wake_target;
  smc_state_e next_wake_target;
  logic [7:0] power_control_reg;
  logic [7:0] next_power_control_reg;
  logic [7:0] watchdog_ctrl_reg;
  logic [7:0] next_watchdog_ctrl_reg;
  logic [7:0] crystal_pin_control_reg;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  wire [7:0] next_irq_status;
  logic [7:0] rst_cnt;
  logic [7:0] next_rst_cnt;
  smc_ctl_s next_ctl;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire sel_power_control_reg = ADDR_IN == SMC_ADDR_POWER_CONTROL_REG;
  wire sel_wdog = ADDR_IN == SMC_ADDR_WDOG;
  wire sel_xtpc = ADDR_IN == SMC_ADDR_XTPC;
  wire sel_istat = ADDR_IN == SMC_ADDR_ISTAT;
  wire sel_imask = ADDR_IN == SMC_ADDR_IMASK;
  wire sel_state = ADDR_IN == SMC_ADDR_STATE;
  // The stopped CPU cannot issue standby writes
  wire cpu_active = state == SMC_ST_NORMAL;
  wire wr_power_control_reg = WR_IN && sel_power_control_reg && cpu_active;
  wire wr_wdog = WR_IN && sel_wdog;
  wire wr_xtpc = WR_IN && sel_xtpc;
  wire wr_istat = WR_IN && sel_istat;
  wire wr_imask = WR_IN && sel_imask;
  wire [7:0] rd_mux =
    sel_power_control_reg ? power_control_reg :
    sel_wdog ? watchdog_ctrl_reg :
    sel_xtpc ? crystal_pin_control_reg :
    sel_istat ? irq_status :
    sel_imask ? irq_mask :
    sel_state ? {5'h00, state} : 8'h00;

  // ----------------------------------------------------------------
  // Wake and reset sources
  // ----------------------------------------------------------------
  wire reset_cause = ext_rst_sync || WDOG_RESET_IN;
  wire hold_wake = WAKE_IN.external_interrupt_0 || WAKE_IN.external_interrupt_1 ||
                   WAKE_IN.external_interrupt_2 || WAKE_IN.external_interrupt_4 ||
                   WAKE_IN.external_interrupt_5 || WAKE_IN.port0_wake_interrupt;
  wire sub_wake = hold_wake || WAKE_IN.base_timer || WAKE_IN.remote_rx;
  wire halt_wake = |WAKE_IN;
  wire in_standby = state == SMC_ST_HALT || state == SMC_ST_HOLD ||
                    state == SMC_ST_SUBHOLD || state == SMC_ST_WAKE;
  wire enter_hold = wr_power_control_reg && WDATA_IN[SMC_POWER_CONTROL_REG_HOLD_BIT];
  wire enter_halt = wr_power_control_reg && !WDATA_IN[SMC_POWER_CONTROL_REG_HOLD_BIT] && WDATA_IN[SMC_POWER_CONTROL_REG_HALT_BIT];
  wire enter_any = enter_hold || enter_halt;
  wire halt_exit = state == SMC_ST_HALT && halt_wake && !reset_cause;
  wire hold_exit = !reset_cause && ((state == SMC_ST_HOLD && hold_wake) ||
                                    (state == SMC_ST_SUBHOLD && sub_wake));
  wire wake_done = state == SMC_ST_WAKE && clk_rdy_sync && !reset_cause;
  wire reset_exit = in_standby && reset_cause;
  wire next_hold_like = next_state == SMC_ST_HOLD || next_state == SMC_ST_SUBHOLD;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_wake_target = wake_target;
    if (reset_cause) begin
      next_state = SMC_ST_RESET;
    end else begin
      unique case (state)
        SMC_ST_RESET: begin
          if (rst_cnt == 8'h00 && clk_rdy_sync) begin
            next_state = SMC_ST_NORMAL;
          end
        end
        SMC_ST_NORMAL: begin
          if (enter_hold) begin
            next_state = WDATA_IN[SMC_POWER_CONTROL_REG_SUB_BIT] ? SMC_ST_SUBHOLD : SMC_ST_HOLD;
          end else if (enter_halt) begin
            next_state = SMC_ST_HALT;
          end
        end
        SMC_ST_HALT: begin
          if (halt_wake) begin
            next_state = SMC_ST_WAKE;
            next_wake_target = SMC_ST_NORMAL;
          end
        end
        SMC_ST_HOLD, SMC_ST_SUBHOLD: begin
          if (hold_exit) begin
            next_state = SMC_ST_WAKE;
            next_wake_target = SMC_ST_HALT;
          end
        end
        SMC_ST_WAKE: begin
          if (clk_rdy_sync) begin
            next_state = wake_target;
          end
        end
        default: begin
          next_state = SMC_ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  always_comb begin
    next_power_control_reg = power_control_reg;
    if (state == SMC_ST_RESET || reset_cause) begin
      next_power_control_reg = SMC_POWER_CONTROL_REG_RST;
    end else if (wr_power_control_reg) begin
      next_power_control_reg = WDATA_IN;
      if (enter_hold) begin
        next_power_control_reg[SMC_POWER_CONTROL_REG_HALT_BIT] = 1'b1;
      end
    end else if (halt_exit) begin
      next_power_control_reg[SMC_POWER_CONTROL_REG_HALT_BIT] = 1'b0;
    end else if (hold_exit) begin
      next_power_control_reg[SMC_POWER_CONTROL_REG_HOLD_BIT] = 1'b0;
    end
  end

  always_comb begin
    next_watchdog_ctrl_reg = watchdog_ctrl_reg;
    if (wr_wdog) begin
      next_watchdog_ctrl_reg = WDATA_IN;
    end else if (enter_any && watchdog_ctrl_reg[SMC_WDOG_CLR_EN_BIT]) begin
      next_watchdog_ctrl_reg = watchdog_ctrl_reg & SMC_WDOG_CNT_MASK;
    end
  end

  // Hold the CPU in reset a fixed time after the last cause clears
  always_comb begin
    next_rst_cnt = rst_cnt;
    if (reset_cause) begin
      next_rst_cnt = SMC_RST_HOLD_CNT;
    end else if (state == SMC_ST_RESET && rst_cnt != 8'h00) begin
      next_rst_cnt = rst_cnt - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  logic [7:0] irq_events;
  wire [7:0] irq_clear = wr_istat ? WDATA_IN : 8'h00;

  always_comb begin
    irq_events = 8'h00;
    irq_events[SMC_IRQ_HALT_WAKE] = halt_exit;
    irq_events[SMC_IRQ_HOLD_WAKE] = hold_exit;
    irq_events[SMC_IRQ_RESET_EXIT] = reset_exit;
    irq_events[SMC_IRQ_CLK_READY] = wake_done;
  end

  // A bit whose event and clear meet in one cycle stays set
  for (genvar i = 0; i < 8; i++) begin : g_irq_bit
    assign next_irq_status[i] = irq_events[i] || (irq_status[i] && !irq_clear[i]);
  end

  // ----------------------------------------------------------------
  // Coming-state decode
  // ----------------------------------------------------------------
  wire nxt_reset = next_state == SMC_ST_RESET;
  wire nxt_normal = next_state == SMC_ST_NORMAL;
  wire nxt_halt = next_state == SMC_ST_HALT;
  wire nxt_hold = next_state == SMC_ST_HOLD;
  wire nxt_subhold = next_state == SMC_ST_SUBHOLD;
  wire nxt_wake = next_state == SMC_ST_WAKE;
  // A base timer that ran into the wake state keeps running until the mode returns
  wire timer_carry = nxt_wake && CTL_OUT.base_timer_run &&
                     (state == SMC_ST_HALT || state == SMC_ST_SUBHOLD || state == SMC_ST_WAKE);

  // ----------------------------------------------------------------
  // Mode outputs, decided from the coming state
  // ----------------------------------------------------------------
  always_comb begin
    next_ctl.cpu_run = nxt_normal;
    next_ctl.cpu_reset = nxt_reset;
    next_ctl.periph_run = nxt_normal || nxt_halt;
    next_ctl.serial_tx_en = nxt_normal;
    next_ctl.base_timer_run = nxt_normal || nxt_halt || nxt_subhold || timer_carry;
    next_ctl.main_osc_en = !next_hold_like;
    next_ctl.sub_osc_en = !nxt_hold;
    next_ctl.osc_pin_gpio = next_hold_like ? CTL_OUT.osc_pin_gpio :
                            crystal_pin_control_reg[SMC_XTPC_SEL_BIT];
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state <= SMC_ST_RESET;
      wake_target <= SMC_ST_NORMAL;
    end else begin
      state <= next_state;
      wake_target <= next_wake_target;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      power_control_reg <= SMC_POWER_CONTROL_REG_RST;
    end else begin
      power_control_reg <= next_power_control_reg;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      watchdog_ctrl_reg <= SMC_WDOG_RST;
    end else begin
      watchdog_ctrl_reg <= next_watchdog_ctrl_reg;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rst_cnt <= SMC_RST_HOLD_CNT;
    end else begin
      rst_cnt <= next_rst_cnt;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      irq_status <= 8'h00;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      crystal_pin_control_reg <= SMC_XTPC_RST;
    end else if (wr_xtpc) begin
      crystal_pin_control_reg <= WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      irq_mask <= SMC_IMASK_RST;
    end else if (wr_imask) begin
      irq_mask <= WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      CTL_OUT <= '0;
      STATE_OUT <= 3'h0;
    end else begin
      CTL_OUT <= next_ctl;
      STATE_OUT <= next_state;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      RDATA_OUT <= RD_IN ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(next_irq_status & irq_mask);
    end
  end

endmodule : smc_standby
`default_nettype wire

// ==== tb/smc_standby_assertions.sv ====
// Port checker of the standby mode controller
`timescale 1ns/10ps
`default_nettype none
module smc_standby_assertions
  import smc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [SMC_AW-1:0] ADDR_IN,
  input wire logic [SMC_DW-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [SMC_DW-1:0] RDATA_OUT,
  input wire smc_wake_s WAKE_IN,
  input wire logic EXT_RESET_PIN_IN,
  input wire logic WDOG_RESET_IN,
  input wire logic MAIN_CLK_READY_IN,
  input wire smc_ctl_s CTL_OUT,
  input wire logic [2:0] STATE_OUT,
  input wire logic IRQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ----------------------------------------------------------------
  // Pin history, so the synchroniser delay never looks like a fault
  // ----------------------------------------------------------------
  logic [2:0] pin_hist;
  logic [2:0] rdy_hist;
  wire logic quiet = !WDOG_RESET_IN && !EXT_RESET_PIN_IN && (pin_hist == 3'h0);
  wire logic slow = !MAIN_CLK_READY_IN && (rdy_hist == 3'h0);
  always_ff @(posedge CLK_IN) begin
    pin_hist <= RST_IN ? 3'h7 : {pin_hist[1:0], EXT_RESET_PIN_IN};
    rdy_hist <= RST_IN ? 3'h7 : {rdy_hist[1:0], MAIN_CLK_READY_IN};
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_reset_exit: assert property (WDOG_RESET_IN |=> STATE_OUT == SMC_ST_RESET)
    else $error("reset cause did not reach reset state");
  a_halt_serial: assert property (STATE_OUT == SMC_ST_HALT |-> !CTL_OUT.serial_tx_en && CTL_OUT.periph_run)
    else $error("halt peripheral state wrong");
  a_hold_stopped: assert property (STATE_OUT inside {SMC_ST_HOLD, SMC_ST_SUBHOLD} |-> !CTL_OUT.periph_run)
    else $error("peripherals run in hold");
  a_timer_run: assert property (STATE_OUT inside {SMC_ST_HALT, SMC_ST_SUBHOLD} |-> CTL_OUT.base_timer_run)
    else $error("base timer stopped in halt or subclock hold");
  a_timer_stop: assert property (STATE_OUT inside {SMC_ST_RESET, SMC_ST_HOLD} |-> !CTL_OUT.base_timer_run)
    else $error("base timer runs in reset or hold");
  a_halt_wake: assert property (STATE_OUT == SMC_ST_HALT && WAKE_IN != 9'h000 && quiet |=> STATE_OUT == SMC_ST_WAKE)
    else $error("halt wake not taken");
  a_hold_wake: assert property (STATE_OUT == SMC_ST_HOLD && WAKE_IN[8:3] != 6'h00 && quiet |=> STATE_OUT == SMC_ST_WAKE)
    else $error("hold wake not taken");
  a_hold_ignore: assert property (STATE_OUT == SMC_ST_HOLD && WAKE_IN[8:3] == 6'h00 && quiet |=> STATE_OUT == SMC_ST_HOLD)
    else $error("hold left without cause");
  a_sub_wake: assert property (STATE_OUT == SMC_ST_SUBHOLD && WAKE_IN[8:1] != 8'h00 && quiet |=> STATE_OUT == SMC_ST_WAKE)
    else $error("subclock hold wake not taken");
  a_pin_frozen: assert property (STATE_OUT == SMC_ST_HOLD && $past(STATE_OUT) == SMC_ST_HOLD |-> $stable(CTL_OUT.osc_pin_gpio))
    else $error("pin select changed in hold");
  a_wake_waits: assert property (STATE_OUT == SMC_ST_WAKE && slow && quiet |=> STATE_OUT == SMC_ST_WAKE)
    else $error("restart before clock ready");
endmodule : smc_standby_assertions
bind smc_standby smc_standby_assertions u_smc_standby_assertions (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .WAKE_IN(WAKE_IN), .EXT_RESET_PIN_IN(EXT_RESET_PIN_IN), .WDOG_RESET_IN(WDOG_RESET_IN),
  .MAIN_CLK_READY_IN(MAIN_CLK_READY_IN), .CTL_OUT(CTL_OUT), .STATE_OUT(STATE_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ==== tb/smc_standby_tb.sv ====
// Self-checking bench of the standby mode controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import smc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin_rst = 1'b0;
  logic wdog_rst = 1'b0;
  logic clk_rdy = 1'b1;
  smc_wake_s wake = 9'h000;
  wire logic [7:0] rdata;
  wire smc_ctl_s ctl;
  wire logic [2:0] state;
  wire logic irq;
  wire logic [3:0] run_bits = {ctl.periph_run, ctl.serial_tx_en, ctl.base_timer_run, ctl.main_osc_en};
  int failures = 0;
  int comparisons = 0;
  int bit_i;
  logic [7:0] d;
  logic [7:0] modes [3] = '{8'h01, 8'h02, 8'h06};
  logic [2:0] tgt [3] = '{SMC_ST_HALT, SMC_ST_HOLD, SMC_ST_SUBHOLD};
  always #2 clk = ~clk;
  smc_standby u_smc_standby (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .WAKE_IN(wake), .EXT_RESET_PIN_IN(pin_rst), .WDOG_RESET_IN(wdog_rst),
    .MAIN_CLK_READY_IN(clk_rdy), .CTL_OUT(ctl), .STATE_OUT(state), .IRQ_OUT(irq));
  // ----------------------------------------------------------------
  // Bus cycles and helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic pulse(input smc_wake_s w);
    @(posedge clk);
    wake <= w;
    @(posedge clk);
    wake <= 9'h000;
  endtask : pulse
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      #1;
      if (state === s) return;
    end
    failures++;
    wrap_up();
  endtask : wait_state
  // Peripheral, serial, base timer, main oscillator enables per state
  function automatic logic [3:0] exp_run(input logic [2:0] s);
    case (s)
      SMC_ST_NORMAL: return 4'hf;
      SMC_ST_HALT: return 4'hb;
      SMC_ST_SUBHOLD: return 4'h2;
      default: return 4'h0;
    endcase
  endfunction : exp_run
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h7d21ebb8));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_state(SMC_ST_NORMAL);
    `CHK("run normal", exp_run(SMC_ST_NORMAL), run_bits)
    rd_reg(16'hfe60, d);
    `CHK("unmapped", 8'h00, d)
    wr_reg(SMC_ADDR_IMASK, 8'h0f);
    for (int m = 0; m < 3; m++) begin
      wr_reg(SMC_ADDR_XTPC, 8'h08);
      wr_reg(SMC_ADDR_WDOG, 8'h17);
      wr_reg(SMC_ADDR_POWER_CONTROL_REG, modes[m]);
      wait_state(tgt[m]);
      `CHK("run", exp_run(tgt[m]), run_bits)
      `CHK("sub osc", logic'(m != 1), ctl.sub_osc_en)
      rd_reg(SMC_ADDR_STATE, d);
      `CHK("state reg", {5'h00, tgt[m]}, d)
      rd_reg(SMC_ADDR_WDOG, d);
      `CHK("wdog", 8'h10, d)
      rd_reg(SMC_ADDR_POWER_CONTROL_REG, d);
      `CHK("power_control_reg entry", modes[m] | 8'h01, d)
      wr_reg(SMC_ADDR_XTPC, 8'h00);
      pulse(m > 0 ? 9'h001 : 9'h000);
      repeat (2) @(posedge clk);
      #1;
      `CHK("no wake", tgt[m], state)
      `CHK("pin", logic'(m > 0), ctl.osc_pin_gpio)
      if (m == 2) begin
        @(posedge clk);
        clk_rdy <= 1'b0;
      end
      bit_i = (m == 0) ? $urandom_range(8, 0) : $urandom_range(8, (m == 1) ? 3 : 1);
      pulse(9'h001 << bit_i);
      if (m == 2) begin
        repeat (6) @(posedge clk);
        #1;
        `CHK("wake wait", SMC_ST_WAKE, state)
        `CHK("cpu held", 1'b0, ctl.cpu_run)
        @(posedge clk);
        clk_rdy <= 1'b1;
      end
      wait_state((m == 0) ? SMC_ST_NORMAL : SMC_ST_HALT);
      rd_reg(SMC_ADDR_POWER_CONTROL_REG, d);
      `CHK("power_control_reg exit", (m == 0) ? 2'b00 : 2'b01, d[1:0])
      rd_reg(SMC_ADDR_ISTAT, d);
      `CHK("status", (m == 0) ? 8'h09 : 8'h0a, d)
      `CHK("irq set", 1'b1, irq)
      if (m > 0) begin
        pulse(9'h100);
        wait_state(SMC_ST_NORMAL);
      end
      wr_reg(SMC_ADDR_ISTAT, 8'h0f);
      repeat (2) @(posedge clk);
      #1;
      `CHK("irq clear", 1'b0, irq)
    end
    wr_reg(SMC_ADDR_POWER_CONTROL_REG, 8'h02);
    wait_state(SMC_ST_HOLD);
    @(posedge clk);
    wdog_rst <= 1'b1;
    wake <= 9'h100;
    @(posedge clk);
    wdog_rst <= 1'b0;
    wake <= 9'h000;
    wait_state(SMC_ST_RESET);
    `CHK("cpu reset", 1'b1, ctl.cpu_reset)
    wait_state(SMC_ST_NORMAL);
    rd_reg(SMC_ADDR_POWER_CONTROL_REG, d);
    `CHK("power_control_reg reset", 8'h00, d)
    rd_reg(SMC_ADDR_ISTAT, d);
    `CHK("status reset", 8'h04, d)
    wr_reg(SMC_ADDR_POWER_CONTROL_REG, 8'h01);
    wait_state(SMC_ST_HALT);
    @(posedge clk);
    pin_rst <= 1'b1;
    repeat (3) @(posedge clk);
    pin_rst <= 1'b0;
    wait_state(SMC_ST_RESET);
    `CHK("pin reset", 1'b1, ctl.cpu_reset)
    wait_state(SMC_ST_NORMAL);
    `CHK("irq pending", 1'b1, irq)
    wr_reg(SMC_ADDR_IMASK, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq masked", 1'b0, irq)
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
